// file: src/acp_pkg.sv
// constants, field positions and carrier types of the converter register block
package acp_pkg;

   // ***************************************************************
   // register indices and byte addresses (byte address = 4 * index)
   // ***************************************************************
   localparam logic [15:0] IDX_CONVERSION_RESULT = 16'h1072;
   localparam logic [15:0] IDX_PIN_DIGITAL_INPUT = 16'h107D;
   localparam logic [15:0] IDX_PIN_FUNCTION_SELECT = 16'h107E;
   localparam logic [15:0] IDX_LEVEL_AND_DEBUG = 16'h107F;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h1080;
   localparam logic [15:0] IDX_IRQ_CLEAR = 16'h1081;
   localparam logic [15:0] IDX_IRQ_ENABLE = 16'h1082;

   localparam logic [15:0] ADDR_CONVERSION_RESULT = IDX_CONVERSION_RESULT << 2;
   localparam logic [15:0] ADDR_PIN_DIGITAL_INPUT = IDX_PIN_DIGITAL_INPUT << 2;
   localparam logic [15:0] ADDR_PIN_FUNCTION_SELECT = IDX_PIN_FUNCTION_SELECT << 2;
   localparam logic [15:0] ADDR_LEVEL_AND_DEBUG = IDX_LEVEL_AND_DEBUG << 2;
   localparam logic [15:0] ADDR_IRQ_STATUS = IDX_IRQ_STATUS << 2;
   localparam logic [15:0] ADDR_IRQ_CLEAR = IDX_IRQ_CLEAR << 2;
   localparam logic [15:0] ADDR_IRQ_ENABLE = IDX_IRQ_ENABLE << 2;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int POS_EMULATION_SUSPEND_ENABLE = 5;
   localparam int POS_PRIORITY_SELECT = 6;
   localparam int POS_FACTORY_TEST_BIT = 7;
   localparam int POS_EVT_CONVERSION_DONE = 0;
   localparam int POS_EVT_FROZEN = 1;
   localparam int NUM_PINS = 8;
   localparam int NUM_EVENTS = 2;

   // ***************************************************************
   // reset values and bus answers
   // ***************************************************************
   localparam logic [7:0] RST_CONVERSION_RESULT = 8'h00;
   localparam logic [7:0] RST_PIN_FUNCTION_SELECT = 8'h00;
   localparam logic [2:0] RST_LEVEL_AND_DEBUG = 3'h0;
   localparam logic [1:0] RST_IRQ = 2'h0;
   localparam logic [2:0] RST_PIN_SYNC = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ***************************************************************
   // carrier types
   // ***************************************************************
   // result handed over by the converter core
   typedef struct packed {
      logic done;
      logic [7:0] data;
   } acp_conv_in_s;

   // debug suspend commands toward the converter core
   typedef struct packed {
      logic freeze;
      logic finish_then_stop;
   } acp_conv_ctl_s;

   // interrupt request split by priority level
   typedef struct packed {
      logic level1;
      logic level2;
   } acp_irq_s;

endpackage

// file: src/acp_regs.sv
// converter result, shared pin port and priority register block on axi4-lite
`timescale 1ns/1ps
`default_nettype none

// ******************************************************************
// Summary of operation
// RULE_01 - the result register loads at each conversion end and holds until the next one.
// RULE_02 - an enabled digital pin shows its present level on its bit of the pin input register.
// RULE_03 - a pin used as an analog channel reads zero in the pin input register.
// RULE_04 - writes to the pin input register change nothing.
// RULE_05 - eight read/write enable bits pick analog (0) or digital (1) per pin, resetting to 0.
// RULE_06 - the emulation suspend enable bit only matters while the debugger suspends execution.
// RULE_07 - with that bit 0 a suspended converter finishes the conversion under way.
// RULE_08 - with that bit 1 a suspended converter freezes and its result counts as indeterminate.
// RULE_09 - the priority select bit routes the converter interrupt to level 1 or level 2.
// RULE_10 - software keeps the factory test bit at zero.
// RULE_11 - the three priority register bits are writable only when privileged, always readable, reset 0.
// RULE_12 - the interrupt flag sets in the same cycle the new result is loaded.
// RULE_13 - priority select 0 means level 1 (high), 1 means level 2 (low).
// ******************************************************************

module acp_regs (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [15:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // converter core and pins
   input wire acp_pkg::acp_conv_in_s conv_in,
   input wire logic [7:0] shared_analog_pins,
   input wire logic emu_suspend,
   output acp_pkg::acp_conv_ctl_s conv_ctl,
   output logic [7:0] pin_digital_enable,
   // interrupts
   output acp_pkg::acp_irq_s irq_route,
   output logic irq
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   logic [7:0] conversion_result_q;
   logic [7:0] shared_pin_function_select_q;
   logic [2:0] level_and_debug_q;   // {test, priority, suspend enable}
   logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_level_q;
   logic [1:0] irq_status_q, irq_enable_q;
   logic frozen_q;
   logic aw_have_q, w_have_q;
   logic [15:0] aw_addr_q;
   logic aw_priv_q;
   logic [7:0] w_data_q;
   logic w_lane0_q;
   logic bvalid_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic do_write, wr_lane;
   logic [1:0] evt_set, evt_clr;
   logic suspend_enable, priority_low, freeze_now;
   logic [7:0] pin_digital_input;
   logic wr_mapped;
   logic [31:0] rd_value;
   logic rd_mapped;

   // ***************************************************************
   // suspend control toward the converter core
   // ***************************************************************
   assign suspend_enable = level_and_debug_q[0];
   assign priority_low = level_and_debug_q[1];
   // the enable bit only acts while suspended; outside that both commands stay low
   assign freeze_now = emu_suspend & suspend_enable;   // RULE_06 RULE_08
   // whole struct in one assignment so the output has a single driver
   assign conv_ctl = '{freeze: freeze_now,   // RULE_08
                       finish_then_stop: emu_suspend & ~suspend_enable};   // RULE_06 RULE_07

   // ***************************************************************
   // conversion result
   // ***************************************************************
   // loads only on a completed conversion, otherwise holds
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conversion_result_q <= acp_pkg::RST_CONVERSION_RESULT;
      end else if (conv_in.done) begin
         conversion_result_q <= conv_in.data;   // RULE_01
      end
   end

   // ***************************************************************
   // shared pin input path
   // ***************************************************************
   // three stages; a level counts only once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
         pin_level_q <= '0;
      end else begin
         pin_s1_q <= shared_analog_pins;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         for (int i = 0; i < acp_pkg::NUM_PINS; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) begin
               pin_level_q[i] <= pin_s3_q[i];
            end
         end
      end
   end

   // analog pins read zero whatever their level
   assign pin_digital_input = pin_level_q & shared_pin_function_select_q;   // RULE_02 RULE_03
   assign pin_digital_enable = shared_pin_function_select_q;

   // ***************************************************************
   // write channel capture
   // ***************************************************************
   // address and data are taken in either order, then held until the write
   assign s_axi_awready = ~aw_have_q & ~bvalid_q;
   assign s_axi_wready = ~w_have_q & ~bvalid_q;
   assign do_write = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_lane = do_write & w_lane0_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 16'h0000;
         aw_priv_q <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
         aw_priv_q <= s_axi_awprot[0];
      end else if (do_write) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         w_data_q <= 8'h00;
         w_lane0_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wdata[7:0];   // registers are at most 8 bits, upper lanes unused
         w_lane0_q <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_have_q <= 1'b0;
      end
   end

   // ***************************************************************
   // writable registers
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shared_pin_function_select_q <= acp_pkg::RST_PIN_FUNCTION_SELECT;   // RULE_05
      end else if (wr_lane && aw_addr_q == acp_pkg::ADDR_PIN_FUNCTION_SELECT) begin
         shared_pin_function_select_q <= w_data_q;   // RULE_05
      end
   end

   // unprivileged writes are dropped silently; test bit is stored as written
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_and_debug_q <= acp_pkg::RST_LEVEL_AND_DEBUG;   // RULE_11
      end else if (wr_lane && aw_priv_q && aw_addr_q == acp_pkg::ADDR_LEVEL_AND_DEBUG) begin
         level_and_debug_q <= {w_data_q[acp_pkg::POS_FACTORY_TEST_BIT],
                               w_data_q[acp_pkg::POS_PRIORITY_SELECT],
                               w_data_q[acp_pkg::POS_EMULATION_SUSPEND_ENABLE]};   // RULE_11
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_enable_q <= acp_pkg::RST_IRQ;
      end else if (wr_lane && aw_addr_q == acp_pkg::ADDR_IRQ_ENABLE) begin
         irq_enable_q <= w_data_q[1:0];
      end
   end

   // ***************************************************************
   // events and interrupt
   // ***************************************************************
   // rising edge of a freeze marks the result as untrustworthy
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frozen_q <= 1'b0;
      end else begin
         frozen_q <= freeze_now;
      end
   end

   always_comb begin
      evt_set = '0;
      evt_set[acp_pkg::POS_EVT_CONVERSION_DONE] = conv_in.done;   // RULE_12
      evt_set[acp_pkg::POS_EVT_FROZEN] = freeze_now & ~frozen_q;   // RULE_08
      evt_clr = '0;
      if (wr_lane && aw_addr_q == acp_pkg::ADDR_IRQ_CLEAR) begin
         evt_clr = w_data_q[1:0];
      end
   end

   // set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_q <= acp_pkg::RST_IRQ;
      end else begin
         irq_status_q <= (irq_status_q & ~evt_clr) | evt_set;   // RULE_12
      end
   end

   assign irq = |(irq_status_q & irq_enable_q);
   // one request, steered to the level the select bit names
   assign irq_route = '{level1: irq & ~priority_low,   // RULE_09 RULE_13
                        level2: irq & priority_low};   // RULE_09 RULE_13

   // ***************************************************************
   // write response
   // ***************************************************************
   // read-only registers accept the write with okay and stay unchanged
   always_comb begin
      unique case (aw_addr_q)
         acp_pkg::ADDR_CONVERSION_RESULT,
         acp_pkg::ADDR_PIN_DIGITAL_INPUT,   // RULE_04
         acp_pkg::ADDR_PIN_FUNCTION_SELECT,
         acp_pkg::ADDR_LEVEL_AND_DEBUG,
         acp_pkg::ADDR_IRQ_STATUS,
         acp_pkg::ADDR_IRQ_CLEAR,
         acp_pkg::ADDR_IRQ_ENABLE: wr_mapped = 1'b1;
         default: wr_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= acp_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_mapped ? acp_pkg::RESP_OKAY : acp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ***************************************************************
   // read path
   // ***************************************************************
   // reserved bits and the write-only clear register read as zero
   always_comb begin
      rd_value = 32'h0000_0000;
      rd_mapped = 1'b1;
      unique case (s_axi_araddr)
         acp_pkg::ADDR_CONVERSION_RESULT: rd_value[7:0] = conversion_result_q;   // RULE_01
         acp_pkg::ADDR_PIN_DIGITAL_INPUT: rd_value[7:0] = pin_digital_input;   // RULE_02
         acp_pkg::ADDR_PIN_FUNCTION_SELECT: rd_value[7:0] = shared_pin_function_select_q;
         acp_pkg::ADDR_LEVEL_AND_DEBUG: begin
            rd_value[acp_pkg::POS_EMULATION_SUSPEND_ENABLE] = level_and_debug_q[0];   // RULE_11
            rd_value[acp_pkg::POS_PRIORITY_SELECT] = level_and_debug_q[1];
            rd_value[acp_pkg::POS_FACTORY_TEST_BIT] = level_and_debug_q[2];
         end
         acp_pkg::ADDR_IRQ_STATUS: rd_value[1:0] = irq_status_q;
         acp_pkg::ADDR_IRQ_CLEAR: rd_value[1:0] = 2'h0;
         acp_pkg::ADDR_IRQ_ENABLE: rd_value[1:0] = irq_enable_q;
         default: rd_mapped = 1'b0;
      endcase
   end

   assign s_axi_arready = ~rvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= acp_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_value;
         rresp_q <= rd_mapped ? acp_pkg::RESP_OKAY : acp_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

endmodule

`default_nettype wire

// file: testbench/acp_conv_model.sv
// behavioural converter core that answers start requests with a done pulse
`timescale 1ns/1ps
`default_nettype none
module acp_conv_model #(
   parameter int LAT = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic [7:0] value,
   input wire acp_pkg::acp_conv_ctl_s conv_ctl,
   output acp_pkg::acp_conv_in_s conv_in
);
   logic [3:0] cnt_q;
   logic [7:0] val_q;
   logic done_q;
   // count down; a freeze holds the count where it stands
   always_ff @(posedge aclk) begin
      done_q <= 1'b0;
      if (!aresetn) begin
         cnt_q <= 4'h0;
      end else if (start) begin
         cnt_q <= 4'(LAT);
         val_q <= value;
      end else if (cnt_q != 4'h0 && !conv_ctl.freeze) begin
         cnt_q <= cnt_q - 4'h1;
         done_q <= (cnt_q == 4'h1);
      end
   end
   // data line is only valid with done, garbage otherwise
   assign conv_in = '{done: done_q, data: done_q ? val_q : ~val_q};
endmodule
`default_nettype wire

// file: testbench/acp_regs_asserts.sv
// assertion checker bound to the converter register block
`timescale 1ns/1ps
`default_nettype none
module acp_regs_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic emu_suspend,
   input wire acp_pkg::acp_conv_ctl_s conv_ctl,
   input wire logic [7:0] pin_digital_enable,
   input wire acp_pkg::acp_irq_s irq_route,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ***************************************************************
   // suspend commands and interrupt routing
   // ***************************************************************
   AST_SUSP_IDLE: assert property (!emu_suspend |-> conv_ctl == 2'b00)
      else $error("suspend command without halt");
   AST_SUSP_ONE: assert property (emu_suspend |-> $onehot(conv_ctl))
      else $error("halt without exactly one suspend command");
   AST_FREEZE: assert property (conv_ctl.freeze |-> emu_suspend)
      else $error("freeze outside halt");
   AST_ROUTE: assert property (irq |-> irq_route.level1 != irq_route.level2)
      else $error("irq not on exactly one level");
   AST_ROUTE_IDLE: assert property (!irq |-> irq_route == 2'b00)
      else $error("level request without irq");
   // ***************************************************************
   // reset values and bus answers
   // ***************************************************************
   AST_RESET_VAL: assert property ($rose(aresetn) |-> pin_digital_enable == 8'h00 && !irq)
      else $error("nonzero state after reset");
   // write and bvalid both land the edge after both are held; bvalid is sampled one edge later
   AST_W_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid)
      else $error("no write response");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule
bind acp_regs acp_regs_asserts u_asserts (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .emu_suspend(emu_suspend),
   .conv_ctl(conv_ctl), .pin_digital_enable(pin_digital_enable), .irq_route(irq_route),
   .irq(irq));
`default_nettype wire

// file: testbench/acp_regs_tb.sv
// self-checking bench for the converter register block
`timescale 1ns/1ps
`default_nettype none
module acp_regs_tb;
   localparam int LAT = 4;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [15:0] awa = 16'h0000, ara = 16'h0000;
   logic [2:0] awp = 3'h0;
   logic [31:0] wd = 32'h0, rdt;
   logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0, emu = 1'b0, start = 1'b0;
   logic [7:0] pins = 8'h00, val = 8'h00, pde;
   logic awr, wr_r, bv, arr, rv, irq;
   logic [1:0] br, rr;
   acp_pkg::acp_conv_in_s conv_in;
   acp_pkg::acp_conv_ctl_s conv_ctl;
   acp_pkg::acp_irq_s irq_route;
   int err_total = 0, n_tests = 0;
   acp_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(awp),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rrd), .conv_in(conv_in), .shared_analog_pins(pins), .emu_suspend(emu),
      .conv_ctl(conv_ctl), .pin_digital_enable(pde), .irq_route(irq_route), .irq(irq));
   acp_conv_model #(.LAT(LAT)) u_conv (.aclk(aclk), .aresetn(aresetn), .start(start),
      .value(val), .conv_ctl(conv_ctl), .conv_in(conv_in));
   // ***************************************************************
   // clock, compare and bus tasks
   // ***************************************************************
   always #5 aclk = ~aclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bready held from the start: legal, and it keeps the slave answer in one cycle
   task automatic wrc(input logic [15:0] a, input logic [7:0] d, input logic p,
      input logic [1:0] er);
      @(posedge aclk);
      awa <= a;
      awp <= {2'b00, p};
      wd <= {24'h000000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
      do begin
         @(posedge aclk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_r) wv <= 1'b0;
      end while (!bv);
      chk(br, er);
      brd <= 1'b0;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
      do begin
         @(posedge aclk);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
      chk(rdt, {24'h000000, d});
      chk(rr, er);
      rrd <= 1'b0;
   endtask
   task automatic conv(input logic [7:0] v);
      @(posedge aclk);
      start <= 1'b1;
      val <= v;
      @(posedge aclk);
      start <= 1'b0;
      repeat (LAT + 3) @(posedge aclk);
   endtask
   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_pins;
      rdc(acp_pkg::ADDR_PIN_FUNCTION_SELECT, 8'h00, 2'h0);
      rdc(acp_pkg::ADDR_LEVEL_AND_DEBUG, 8'h00, 2'h0);
      @(posedge aclk);
      pins <= 8'hA5;
      wrc(acp_pkg::ADDR_PIN_FUNCTION_SELECT, 8'h0F, 1'b0, 2'h0);
      repeat (6) @(posedge aclk);
      rdc(acp_pkg::ADDR_PIN_DIGITAL_INPUT, 8'h05, 2'h0);
      wrc(acp_pkg::ADDR_PIN_DIGITAL_INPUT, 8'hFF, 1'b1, 2'h0);
      rdc(acp_pkg::ADDR_PIN_DIGITAL_INPUT, 8'h05, 2'h0);
      chk(pde, 8'h0F);
      pins <= 8'h5A;
      repeat (6) @(posedge aclk);
      rdc(acp_pkg::ADDR_PIN_DIGITAL_INPUT, 8'h0A, 2'h0);
   endtask
   task automatic t_result;
      wrc(acp_pkg::ADDR_IRQ_ENABLE, 8'h01, 1'b0, 2'h0);
      conv(8'h3C);
      rdc(acp_pkg::ADDR_IRQ_STATUS, 8'h01, 2'h0);
      chk(irq, 1'b1);
      repeat (5) @(posedge aclk);
      rdc(acp_pkg::ADDR_CONVERSION_RESULT, 8'h3C, 2'h0);
      conv(8'hC3);
      rdc(acp_pkg::ADDR_CONVERSION_RESULT, 8'hC3, 2'h0);
      // unprivileged write must leave the priority bits alone
      wrc(acp_pkg::ADDR_LEVEL_AND_DEBUG, 8'h40, 1'b0, 2'h0);
      rdc(acp_pkg::ADDR_LEVEL_AND_DEBUG, 8'h00, 2'h0);
      chk(irq_route, 2'b10);
      wrc(acp_pkg::ADDR_LEVEL_AND_DEBUG, 8'h40, 1'b1, 2'h0);
      rdc(acp_pkg::ADDR_LEVEL_AND_DEBUG, 8'h40, 2'h0);
      chk(irq_route, 2'b01);
      wrc(acp_pkg::ADDR_IRQ_CLEAR, 8'h03, 1'b0, 2'h0);
      chk(irq, 1'b0);
   endtask
   task automatic t_susp;
      wrc(acp_pkg::ADDR_LEVEL_AND_DEBUG, 8'h20, 1'b1, 2'h0);
      chk(conv_ctl, 2'b00);
      emu <= 1'b1;
      @(posedge aclk);
      chk(conv_ctl, 2'b10);
      conv(8'h99);
      rdc(acp_pkg::ADDR_IRQ_STATUS, 8'h02, 2'h0);
      rdc(acp_pkg::ADDR_CONVERSION_RESULT, 8'hC3, 2'h0);
      emu <= 1'b0;
      repeat (LAT + 2) @(posedge aclk);
      rdc(acp_pkg::ADDR_CONVERSION_RESULT, 8'h99, 2'h0);
      wrc(acp_pkg::ADDR_LEVEL_AND_DEBUG, 8'h00, 1'b1, 2'h0);
      emu <= 1'b1;
      @(posedge aclk);
      chk(conv_ctl, 2'b01);
      emu <= 1'b0;
      // unmapped place answers with an error both ways
      wrc(16'h0000, 8'h11, 1'b1, acp_pkg::RESP_SLVERR);
      rdc(16'h0000, 8'h00, acp_pkg::RESP_SLVERR);
   endtask
   task automatic close_out;
      $display("mismatches %0d, comparisons %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ***************************************************************
   // main sequence and watchdog
   // ***************************************************************
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_pins();
      t_result();
      t_susp();
      close_out();
   end
   // run needs well under a thousand cycles
   initial begin
      #100000;
      err_total++;
      close_out();
   end
endmodule
`default_nettype wire
